// [hdl/fifo_ctl_pkg.sv]
/*
  shared constants for the sample buffer flush and watermark control slice.
  assumes a host serial front end that presents byte register accesses.
*/
`default_nettype none
package fifo_ctl_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CTRL_ADDR   = 8'h27; // fifo_flush_watermark_ctrl
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam int         FLUSH_BIT   = 7;
  localparam int         SEL_BIT     = 6;
  localparam int         WM_MSB      = 5;
  localparam int         WM_W        = 6;
  // ************************************************************
  // buffer geometry and modes
  // ************************************************************
  localparam int         DEPTH       = 32;
  localparam logic [5:0] DEPTH_CNT   = 6'h20;
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_STREAM = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [1:0] MODE_TRIG   = 2'h3;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  // triggered-mode collection phases
  typedef enum logic [1:0] {PH_PRE, PH_POST, PH_DONE} trig_phase_t;
endpackage : fifo_ctl_pkg
`default_nettype wire

// [hdl/fifo_flush_wm_ctrl.sv]
/*
  control slice of the sample buffer: flush command, watermark flag,
  triggered-mode capture limits and buffer hold of the wake state.
  the sample storage itself lives in the datapath; this slice keeps only
  the count, the flags and the triggered-mode collection phase.
  assumes the serial front end gives one-cycle reg_wr/reg_rd strobes and
  that sample push/pop strobes come from the buffer datapath.
*/
// Behaviour
// - flush discards samples and clears flags
// - flush also clears gate error and count
// - flush bit self-clears, always reads zero
// - selector zero ignores buffer flags for wake
// - selector one: flags set at expiry sleeps
// - host clearing flags restarts timer, stays awake
// - selector only matters in stream or stop
// - watermark flag when count reaches threshold
// - zero threshold disables watermark flag
// - triggered mode threshold caps pre-trigger samples
// - disabled mode flushes and clears flags, count
// - after trigger collect 32 minus threshold, stop
`timescale 1ns/1ps
`default_nettype none
module fifo_flush_wm_ctrl #(
  parameter int PW = 8
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // register port
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata_r,
  // buffer datapath and mode
  input  wire logic [1:0]    buf_mode,
  input  wire logic          sample_push,
  input  wire logic          sample_pop,
  input  wire logic          trig_in,
  output logic      [5:0]    buf_count_r,
  output logic               watermark_flag_r,
  output logic               overflow_flag_r,
  output logic               gate_clear_r,
  // auto-wake/sleep
  input  wire logic          odr_tick,
  input  wire logic          wake_event,
  input  wire logic [PW-1:0] auto_sleep_period,
  output logic               wake_r
);
  // ************************************************************
  // register
  // ************************************************************
  logic                  wake_hold_selector_r;
  logic [5:0]            watermark_threshold_r;
  logic                  flush_r;
  fifo_ctl_pkg::trig_phase_t phase_r;
  logic                  expired;

  // one mapped address: other writes are dropped, other reads give zero
  wire ctrl_hit  = reg_addr == fifo_ctl_pkg::CTRL_ADDR;
  wire wr_hit    = reg_wr && ctrl_hit;
  wire flush_cmd = wr_hit && reg_wdata[fifo_ctl_pkg::FLUSH_BIT];
  wire [7:0] ctrl_view = {1'b0, wake_hold_selector_r, watermark_threshold_r};

  // self-clearing flush
  // only selector and threshold are read back, so bit 7 never reads as one
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_hold_selector_r  <= 1'b0;
      watermark_threshold_r <= 6'h00;
      flush_r               <= 1'b0;
      reg_rdata_r           <= fifo_ctl_pkg::CTRL_RESET;
    end else begin
      flush_r <= flush_cmd;
      if (wr_hit) begin
        wake_hold_selector_r  <= reg_wdata[fifo_ctl_pkg::SEL_BIT];
        watermark_threshold_r <= reg_wdata[fifo_ctl_pkg::WM_MSB:0];
      end
      if (reg_rd) begin
        reg_rdata_r <= ctrl_hit ? ctrl_view : 8'h00;
      end
    end
  end

  // ************************************************************
  // sample count
  // ************************************************************
  // mode decode shared by storage, overflow and the wake hold
  wire mode_off    = buf_mode == fifo_ctl_pkg::MODE_OFF;
  wire mode_stream = buf_mode == fifo_ctl_pkg::MODE_STREAM;
  wire mode_stop   = buf_mode == fifo_ctl_pkg::MODE_STOP;
  wire mode_trig   = buf_mode == fifo_ctl_pkg::MODE_TRIG;
  wire full        = buf_count_r == fifo_ctl_pkg::DEPTH_CNT;
  wire pre_phase   = phase_r == fifo_ctl_pkg::PH_PRE;
  wire post_phase  = phase_r == fifo_ctl_pkg::PH_POST;
  wire done_phase  = phase_r == fifo_ctl_pkg::PH_DONE;

  // disabled mode acts as a standing flush
  wire flush_all = flush_cmd || mode_off;
  // pre-trigger samples capped at threshold
  // a threshold above the depth must not let the count pass full, so the
  // cap also applies once the buffer is full; the oldest sample is dropped
  wire pre_cap   = mode_trig && pre_phase &&
                   ((buf_count_r >= watermark_threshold_r) || full);
  // no storage once the post-trigger run is done
  wire push_ok   = sample_push && !mode_off && !(mode_stop && full) &&
                   !(mode_trig && (done_phase || (post_phase && full)));
  // stream mode and pre-trigger drop the oldest, so the count holds
  wire count_up  = push_ok && !(mode_stream && full) && !pre_cap;
  wire pop_ok    = sample_pop && (buf_count_r != 6'h00);
  wire [5:0] count_step = buf_count_r + {5'h00, count_up}
                          - {5'h00, pop_ok};
  wire [5:0] count_nxt  = flush_all ? 6'h00 : count_step;
  wire       emptied    = count_nxt == 6'h00;
  // only a read that drains the buffer re-arms the trigger; a buffer that
  // is empty right after a trigger with a zero threshold must not
  wire       host_empty = pop_ok && emptied;

  wire wm_nxt = (watermark_threshold_r != 6'h00) &&
                (count_nxt >= watermark_threshold_r);
  // overflow marks the end of the post-trigger run; it uses the same
  // test as the phase change, so a trigger on a full buffer still ends
  wire ovf_set = (sample_push && full && (mode_stream || mode_stop)) ||
                 (mode_trig && post_phase &&
                  (count_nxt == fifo_ctl_pkg::DEPTH_CNT));
  wire ovf_nxt = (overflow_flag_r && !(flush_all || emptied)) ||
                 (ovf_set && !flush_all);

  // flags follow the next count every cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      buf_count_r      <= 6'h00;
      watermark_flag_r <= 1'b0;
      overflow_flag_r  <= 1'b0;
      gate_clear_r     <= 1'b0;
    end else begin
      buf_count_r      <= count_nxt;
      watermark_flag_r <= wm_nxt;
      overflow_flag_r  <= ovf_nxt;
      // gate error and gate count clear
      gate_clear_r     <= flush_all || (pop_ok && emptied);
    end
  end

  // ************************************************************
  // triggered-mode phases
  // ************************************************************
  // later triggers ignored until flushed or emptied
  // leaving triggered mode always returns to the armed phase
  always_ff @(posedge clock) begin
    if (rst || !mode_trig) begin
      phase_r <= fifo_ctl_pkg::PH_PRE;
    end else begin
      unique case (phase_r)
        fifo_ctl_pkg::PH_PRE: begin
          if (trig_in) begin
            phase_r <= fifo_ctl_pkg::PH_POST;
          end
        end
        fifo_ctl_pkg::PH_POST: begin
          if (flush_all || host_empty) begin
            phase_r <= fifo_ctl_pkg::PH_PRE;
          end else if (count_nxt == fifo_ctl_pkg::DEPTH_CNT) begin
            phase_r <= fifo_ctl_pkg::PH_DONE;
          end
        end
        fifo_ctl_pkg::PH_DONE: begin
          if (flush_all || host_empty) begin
            phase_r <= fifo_ctl_pkg::PH_PRE;
          end
        end
        // the spare state code falls back to the armed phase
        default: begin
          phase_r <= fifo_ctl_pkg::PH_PRE;
        end
      endcase
    end
  end

  // ************************************************************
  // auto-wake/sleep
  // ************************************************************
  // selector counts only in stream or stop mode
  wire sel_eff    = wake_hold_selector_r && (mode_stream || mode_stop);
  wire flags_set  = watermark_flag_r || overflow_flag_r;
  // host flush or read while flags are set restarts the timer
  wire host_clear = sel_eff && flags_set && (flush_cmd || pop_ok);
  // without the selector buffer flags never restart the timer
  wire restart    = host_clear || wake_event || !wake_r;
  // after a trigger the part stays awake regardless of the period
  wire go_sleep   = expired && !(mode_trig && !pre_phase);
  wire go_wake    = wake_event || (mode_trig && trig_in && pre_phase);

  // the timer is held clear while asleep, so every wake gets a full period
  sleep_timer #(
    .PW (PW)
  ) u_timer (
    .clock    (clock),
    .rst      (rst),
    .odr_tick (odr_tick),
    .restart  (restart),
    .run      (wake_r),
    .period   (auto_sleep_period),
    .expired  (expired)
  );

  // flags still set at expiry do not hold wake
  // a wake event in the expiry cycle wins, so fresh activity is not lost
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_r <= 1'b1;
    end else if (!wake_r) begin
      wake_r <= go_wake;
    end else if (go_sleep && !host_clear && !wake_event) begin
      wake_r <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // flush and register view
  chk_flush_empties: assert property (
    flush_cmd |=> (buf_count_r == 6'h00) && !overflow_flag_r
                  && !watermark_flag_r)
    else $error("flush left samples or flags");
  chk_flush_gate: assert property (
    flush_cmd |=> gate_clear_r)
    else $error("flush did not clear gate fields");
  chk_flush_reads0: assert property (
    reg_rd ##1 1'b1 |-> !reg_rdata_r[fifo_ctl_pkg::FLUSH_BIT])
    else $error("flush bit read as one");
  chk_flush_gap: assert property (
    flush_r |-> gate_clear_r && buf_count_r == 6'h00)
    else $error("cycle after flush not cleared");

  // auto-wake/sleep hold
  chk_nosel_norestart: assert property (
    !sel_eff && !wake_event && wake_r |-> !restart)
    else $error("timer restarted by buffer without selector");
  chk_expiry_sleeps: assert property (
    wake_r && expired && !host_clear && !wake_event && !mode_trig
      |=> !wake_r)
    else $error("expiry did not enter sleep");
  chk_clear_stays: assert property (
    wake_r && host_clear |=> wake_r && !expired)
    else $error("host clear did not keep wake");
  chk_sel_modes: assert property (
    (mode_off || mode_trig) |-> !sel_eff)
    else $error("selector active in wrong mode");
  chk_nosel_sleeps: assert property (
    wake_r && expired && !sel_eff && !wake_event && !mode_trig
      |=> !wake_r)
    else $error("buffer activity held wake without selector");
  chk_trig_awake: assert property (
    wake_r && mode_trig && !pre_phase |=> wake_r)
    else $error("slept while collecting after trigger");

  // watermark flag
  chk_wm_flag: assert property (
    ##1 (watermark_threshold_r == $past(watermark_threshold_r))
      && watermark_threshold_r != 6'h00
      |-> watermark_flag_r == (buf_count_r >= watermark_threshold_r))
    else $error("watermark flag disagrees with count");
  chk_wm_zero: assert property (
    ##1 $past(watermark_threshold_r) == 6'h00 |-> !watermark_flag_r)
    else $error("watermark flag with zero threshold");

  // triggered collection and count tracking
  chk_pre_cap: assert property (
    mode_trig && pre_phase && buf_count_r >= watermark_threshold_r
      && !sample_pop && !flush_cmd |=> buf_count_r == $past(buf_count_r))
    else $error("pre-trigger count exceeded threshold");
  chk_off_clears: assert property (
    mode_off |=> buf_count_r == 6'h00 && !overflow_flag_r)
    else $error("disabled mode kept samples");
  chk_done_ovf: assert property (
    mode_trig && post_phase && count_nxt == fifo_ctl_pkg::DEPTH_CNT
      && !flush_all |=> overflow_flag_r && done_phase)
    else $error("post-trigger run did not stop with overflow");
  chk_trig_ignored: assert property (
    mode_trig && done_phase && trig_in && !flush_all && !sample_pop
      |=> done_phase)
    else $error("trigger re-armed before flush or empty");
  chk_count_depth: assert property (
    buf_count_r <= fifo_ctl_pkg::DEPTH_CNT)
    else $error("sample count above buffer depth");
  chk_wm_follow: assert property (
    $changed(buf_count_r) && watermark_threshold_r != 6'h00
      && $stable(watermark_threshold_r)
      |-> watermark_flag_r == (buf_count_r >= watermark_threshold_r))
    else $error("watermark not re-evaluated on count change");


  // ************************************************************
  // cover points
  // ************************************************************
  // main scenarios: flush, watermark, trigger run, sleep, held wake
  cov_flush: cover property (flush_cmd ##1 buf_count_r == 6'h00);
  cov_wm: cover property ($rose(watermark_flag_r));
  cov_trig_done: cover property (post_phase ##[1:64] done_phase);
  cov_sleep: cover property (wake_r ##1 !wake_r);
  cov_hold_wake: cover property (host_clear ##1 wake_r);
endmodule : fifo_flush_wm_ctrl
`default_nettype wire

// [hdl/sleep_timer.sv]
/*
  auto-sleep period counter advanced by an output-data-rate enable.
  assumes odr_tick is a one-cycle pulse from a divider on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sleep_timer #(
  parameter int PW = 8
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // control
  input  wire logic          odr_tick,
  input  wire logic          restart,
  input  wire logic          run,
  input  wire logic [PW-1:0] period,
  // result
  output logic               expired
);
  logic [PW-1:0] cnt_r;
  wire           at_end = (cnt_r >= period) && (period != '0);

  // count ticks while awake; a zero period never expires
  always_ff @(posedge clock) begin
    if (rst || restart || !run) begin
      cnt_r   <= '0;
      expired <= 1'b0;
    end else begin
      expired <= odr_tick && at_end;
      if (odr_tick && !at_end) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : sleep_timer
`default_nettype wire

// [verif/fifo_flush_wm_ctrl_tb.sv]
/*
  self-checking bench for the flush and watermark control slice.
  assumes host_model drives the register port; bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module fifo_flush_wm_ctrl_tb;
  logic clock = 1'b0, rst = 1'b1, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r;
  logic [1:0] buf_mode = 2'h1;
  logic sample_push = 1'b0, sample_pop = 1'b0, trig_in = 1'b0;
  logic odr_tick = 1'b0, wake_event = 1'b0;
  logic [7:0] auto_sleep_period = 8'h02;
  logic [5:0] buf_count_r;
  logic watermark_flag_r, overflow_flag_r, gate_clear_r, wake_r;
  int bad_count = 0, tests_run = 0, cycles = 0;
  always #5 clock = ~clock;
  host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  fifo_flush_wm_ctrl #(.PW(8)) uut (.clock(clock), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .buf_mode(buf_mode), .sample_push(sample_push),
    .sample_pop(sample_pop), .trig_in(trig_in), .buf_count_r(buf_count_r),
    .watermark_flag_r(watermark_flag_r), .overflow_flag_r(overflow_flag_r),
    .gate_clear_r(gate_clear_r), .odr_tick(odr_tick),
    .wake_event(wake_event), .auto_sleep_period(auto_sleep_period),
    .wake_r(wake_r));
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  // ************************************************************
  // stimulus helpers
  // ************************************************************
  // n back-to-back pushes, then let the count settle
  task automatic push(input int n);
    @(posedge clock);
    sample_push <= 1'b1;
    repeat (n) @(posedge clock);
    sample_push <= 1'b0;
    #1;
  endtask : push
  // one rate tick; two idle cycles let expiry reach wake_r
  task automatic tick;
    @(posedge clock);
    odr_tick <= 1'b1;
    @(posedge clock);
    odr_tick <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : tick
  task automatic wake_up;
    @(posedge clock);
    wake_event <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    push(1);
    tick();
  endtask : wake_up
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    host.rd(8'h27);
    chk("reset value", 8'h00, reg_rdata_r);
    host.wr(8'h27, 8'h45);
    host.rd(8'h28);
    chk("unmapped read", 8'h00, reg_rdata_r);
    host.wr(8'h27, 8'h85);
    chk("gate clear", 8'h01, {7'h0, gate_clear_r});
    host.rd(8'h27);
    chk("ctrl read", 8'h05, reg_rdata_r);
    host.wr(8'h27, 8'h02);
    push(2);
    chk("wm at threshold", 8'h01, {7'h0, watermark_flag_r});
    @(posedge clock);
    sample_pop <= 1'b1;
    @(posedge clock);
    sample_pop <= 1'b0;
    #1;
    chk("count after pop", 8'h01, {2'h0, buf_count_r});
    chk("wm after pop", 8'h00, {7'h0, watermark_flag_r});
    push(3);
    host.wr(8'h27, 8'h80);
    chk("count flushed", 8'h00, {2'h0, buf_count_r});
    chk("gate clear flush", 8'h01, {7'h0, gate_clear_r});
    push(3);
    chk("wm disabled", 8'h00, {7'h0, watermark_flag_r});
    // triggered mode: pre-trigger cap, then the remainder fills to depth
    host.wr(8'h27, 8'h04);
    @(posedge clock);
    buf_mode <= 2'h3;
    push(6);
    chk("pre trigger cap", 8'h04, {2'h0, buf_count_r});
    @(posedge clock);
    trig_in <= 1'b1;
    @(posedge clock);
    trig_in <= 1'b0;
    push(40);
    chk("post trigger count", 8'h20, {2'h0, buf_count_r});
    chk("ovf set", 8'h01, {7'h0, overflow_flag_r});
    @(posedge clock);
    buf_mode <= 2'h0;
    repeat (2) @(posedge clock);
    #1;
    chk("off count", 8'h00, {2'h0, buf_count_r});
    chk("off flags", 8'h00, {6'h0, overflow_flag_r, watermark_flag_r});
    // wake hold: selector off keeps timer running through a flush
    @(posedge clock);
    buf_mode <= 2'h1;
    host.wr(8'h27, 8'h01);
    wake_up();
    host.wr(8'h27, 8'h81);
    tick();
    tick();
    chk("sleep sel off", 8'h00, {7'h0, wake_r});
    // selector must already be stored when the flush arrives
    host.wr(8'h27, 8'h41);
    wake_up();
    host.wr(8'h27, 8'hc1);
    tick();
    tick();
    chk("awake after flush", 8'h01, {7'h0, wake_r});
    push(1);
    chk("wm set at expiry", 8'h01, {7'h0, watermark_flag_r});
    tick();
    chk("sleep at expiry", 8'h00, {7'h0, wake_r});
    // stop mode: a read with flags set restarts the timer
    @(posedge clock);
    buf_mode <= 2'h2;
    wake_up();
    tick();
    @(posedge clock);
    sample_pop <= 1'b1;
    @(posedge clock);
    sample_pop <= 1'b0;
    tick();
    tick();
    chk("awake in stop", 8'h01, {7'h0, wake_r});
    finish_test();
  end
endmodule : fifo_flush_wm_ctrl_tb
`default_nettype wire

// [verif/host_model.sv]
/*
  host side of the register port: single byte writes and reads.
  assumes the bench samples reg_rdata_r itself once a read returns.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       clock,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // one strobe per access; idle bus shows the inverted address, and inverted data after a write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
  endtask : rd
endmodule : host_model
`default_nettype wire
